// *** rtl/rpmc_pkg.sv ***
package rpmc_pkg;

  // APB address width and register indices; byte address is four times the index
  localparam int RPMC_ADDR_W = 12;
  localparam logic [7:0] PCTL_IDX = 8'h87;
  localparam logic [7:0] WAKE_CFG_IDX = 8'h88;
  localparam logic [7:0] MODE_STAT_IDX = 8'h89;
  localparam logic [11:0] PCTL_ADDR = {2'h0, PCTL_IDX, 2'h0};
  localparam logic [11:0] WAKE_CFG_ADDR = {2'h0, WAKE_CFG_IDX, 2'h0};
  localparam logic [11:0] MODE_STAT_ADDR = {2'h0, MODE_STAT_IDX, 2'h0};

  // power_control fields
  localparam int IDLE_BIT = 0;
  localparam int PWRDN_BIT = 1;
  localparam int GFLAG0_BIT = 2;
  localparam int GFLAG1_BIT = 3;
  localparam int PWROFF_BIT = 4;
  localparam int RSVD_BIT = 5;
  localparam int FRAME_SEL_BIT = 6;
  localparam int BAUD_DBL_BIT = 7;
  localparam logic [7:0] PCTL_RST = 8'h00;

  // wake_config fields
  localparam int WK_EN_IRQ0_BIT = 0;
  localparam int WK_EN_IRQ1_BIT = 1;
  localparam int WK_EN_KBD_BIT = 2;
  localparam int WK_EN_USB_BIT = 3;
  localparam int WK_EDGE_IRQ0_BIT = 4;
  localparam int WK_EDGE_IRQ1_BIT = 5;
  localparam logic [7:0] WAKE_CFG_RST = 8'h00;

  // mode_status fields
  localparam int ST_IDLE_BIT = 0;
  localparam int ST_SLEEP_BIT = 1;
  localparam int ST_OSC_BIT = 2;
  localparam int ST_KBD_BIT = 3;
  localparam int ST_RST_BIT = 4;

  // Timing, in oscillator clock periods
  localparam int RST_PULSE_CYCLES = 96;
  localparam int POR_DELAY_CYCLES = 1024;
  localparam int KBD_WAKE_CYCLES = 1024;
  localparam int EXT_RST_MIN_CYCLES = 24;

  typedef enum logic [1:0] {PM_OFF, PM_WAIT_XTAL, PM_COUNT, PM_RUN} rpmc_pm_state_t;
  typedef enum logic [2:0] {MD_RUN, MD_IDLE, MD_DOWN_SLEEP, MD_DOWN_OSC, MD_DOWN_KBD}
    rpmc_mode_t;

endpackage

// *** rtl/rpmc_delay.sv ***
`timescale 1ns/100ps
module rpmc_delay #(
  parameter int COUNT = 16
) (
  input wire logic clock_i,
  input wire logic clear_i,
  input wire logic run_i,
  output logic done_o
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] count_r;

  // Saturates at the last count so done stays up while run is held
  always_ff @(posedge clock_i) begin
    if (clear_i) begin
      count_r <= '0;
    end else if (run_i && count_r != LAST) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign done_o = run_i && !clear_i && (count_r == LAST);
endmodule

// *** rtl/rpmc_top.sv ***
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
// How it works
// - Internal reset merges power monitor, watchdog, counter-array watchdog, reset pin.
// - Watchdog overflow pulls the reset pin low for 96 clock periods.
// - Supply below safe level holds internal reset from power-up on.
// - Safe supply and toggling crystal start 1024 clocks before reset release.
// - Supply dropping while running asserts internal reset with no delay.
// - Setting idle bit gates CPU clock; interrupts, timers, serial keep clocks.
// - Idle keeps CPU state and ports; both strobes held high.
// - Enabled interrupt in idle clears idle bit and restarts the CPU.
// - Hardware reset ends idle; pin must stay low 24 clock periods.
// - Power-down bit stops the oscillator; registers are kept meanwhile.
// - Power-down ends only on reset or enabled external, keyboard, USB wake.
// - Keyboard wake waits 1024 clocks before running again.
// - Low wake pin restarts oscillator; first release finishes the exit.
// - After wake service the CPU continues after the power-down instruction.
// - Reset exit reinitialises registers; interrupt exit keeps them.
// - Idle plus power-down bits behave as power-down; both cleared on exit.
// - Low power with internal memory: port 0 only drives zeros.
// - Power-off flag set at power-up, software may set or clear it.
// - Two general flags are plain software storage.
// - Power-down bit set by software, cleared by any reset.
// - Bit 7 doubles baud rate; bit 6 selects framing error flag view.
// - Reserved bit 5 reads zero.
module rpmc_top
  import rpmc_pkg::*;
#(
  parameter int RST_PULSE = rpmc_pkg::RST_PULSE_CYCLES,
  parameter int POR_CYCLES = rpmc_pkg::POR_DELAY_CYCLES,
  parameter int KBD_CYCLES = rpmc_pkg::KBD_WAKE_CYCLES,
  parameter int EXT_RST_MIN = rpmc_pkg::EXT_RST_MIN_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [rpmc_pkg::RPMC_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SUPPLY_OK_I,
  input wire logic CRYSTAL_OK_I,
  input wire logic WATCHDOG_OVF_I,
  input wire logic PCA_WATCHDOG_RST_I,
  input wire logic RST_PIN_N_I,
  output logic RST_PIN_O,
  output logic RST_PIN_OE_O,
  input wire logic IRQ_PENDING_I,
  input wire logic EXT_IRQ0_N_I,
  input wire logic EXT_IRQ1_N_I,
  input wire logic KBD_IRQ_I,
  input wire logic USB_IRQ_I,
  input wire logic EXT_PROG_MEM_I,
  input wire logic ADDR_LATCH_CORE_I,
  input wire logic PROG_STROBE_CORE_I,
  input wire logic [7:0] P0_LATCH_I,
  input wire logic [7:0] P0_CORE_OE_I,
  input wire logic [7:0] P2_DATA_I,
  input wire logic [7:0] P2_ADDR_I,
  input wire logic P2_ADDR_SEL_I,
  output logic [7:0] P0_O,
  output logic [7:0] P0_OE_O,
  output logic [7:0] P2_O,
  output logic ADDR_LATCH_STROBE_O,
  output logic PROG_STROBE_O,
  output logic INTERNAL_RST_O,
  output logic CPU_CLK_EN_O,
  output logic PERIPH_CLK_EN_O,
  output logic OSC_EN_O,
  output logic BAUD_DOUBLE_O,
  output logic FRAME_ERR_SEL_O
);
  import rpmc_pkg::*;

  logic [7:0] pctl_r;
  logic [7:0] wake_cfg_r;
  rpmc_pm_state_t pm_state_r, pm_state_nxt;
  rpmc_mode_t mode_r, mode_nxt;
  logic int_rst_r;
  logic pin_oe_r, pin_val_r;
  logic pulse_done, por_done, kbd_done, ext_rst_done;
  logic pof_set, clr_idle, clr_both;
  logic low_pw, in_down;
  logic [1:0] irq_low, irq_prev_r, irq_fall, edge_seen_r, held_r, irq_req;
  logic kbd_req, usb_req, release_any;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic setup, access, aligned, mapped, pctl_wr, wake_wr;
  logic cpu_en_r, periph_en_r, osc_en_r;
  logic ale_r, pstb_r;
  logic [7:0] p0_r, p0_oe_r, p2_r;
  logic [15:0] por_seen_r;

  // APB slave
  assign setup = PSEL_I && !PENABLE_I;
  assign access = PSEL_I && PENABLE_I && pready_r;
  assign aligned = (PADDR_I[1:0] == 2'h0);
  assign mapped = aligned && (PADDR_I == PCTL_ADDR || PADDR_I == WAKE_CFG_ADDR ||
                              PADDR_I == MODE_STAT_ADDR);
  assign pctl_wr = access && PWRITE_I && (PADDR_I == PCTL_ADDR) && !int_rst_r;
  assign wake_wr = access && PWRITE_I && (PADDR_I == WAKE_CFG_ADDR) && !int_rst_r;

  // One wait-free access phase: the answer is prepared during setup
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r <= 32'h0000_0000;
      if (setup && !PWRITE_I && aligned) begin
        if (PADDR_I == PCTL_ADDR) begin
          prdata_r <= {24'h00_0000, pctl_r & ~(8'h01 << RSVD_BIT)};
        end else if (PADDR_I == WAKE_CFG_ADDR) begin
          prdata_r <= {24'h00_0000, wake_cfg_r};
        end else if (PADDR_I == MODE_STAT_ADDR) begin
          prdata_r <= {27'h000_0000, int_rst_r, mode_r == MD_DOWN_KBD,
                       mode_r == MD_DOWN_OSC, mode_r == MD_DOWN_SLEEP, mode_r == MD_IDLE};
        end
      end
    end
  end

  assign pof_set = (pm_state_r == PM_OFF) && SUPPLY_OK_I;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pctl_r <= PCTL_RST;
    end else begin
      if (int_rst_r) begin
        pctl_r[BAUD_DBL_BIT] <= 1'b0;
        pctl_r[FRAME_SEL_BIT] <= 1'b0;
        pctl_r[GFLAG1_BIT] <= 1'b0;
        pctl_r[GFLAG0_BIT] <= 1'b0;
        pctl_r[PWRDN_BIT] <= 1'b0;
        pctl_r[IDLE_BIT] <= 1'b0;
      end else begin
        if (pctl_wr) begin
          pctl_r[BAUD_DBL_BIT] <= PWDATA_I[BAUD_DBL_BIT];
          pctl_r[FRAME_SEL_BIT] <= PWDATA_I[FRAME_SEL_BIT];
          pctl_r[PWROFF_BIT] <= PWDATA_I[PWROFF_BIT];
          pctl_r[GFLAG1_BIT] <= PWDATA_I[GFLAG1_BIT];
          pctl_r[GFLAG0_BIT] <= PWDATA_I[GFLAG0_BIT];
          pctl_r[PWRDN_BIT] <= PWDATA_I[PWRDN_BIT];
          pctl_r[IDLE_BIT] <= PWDATA_I[IDLE_BIT];
        end
        if (clr_idle || clr_both) begin
          pctl_r[IDLE_BIT] <= 1'b0;
        end
        if (clr_both) begin
          pctl_r[PWRDN_BIT] <= 1'b0;
        end
      end
      // hardware set wins over a clear
      if (pof_set) begin
        pctl_r[PWROFF_BIT] <= 1'b1;
      end
      pctl_r[RSVD_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I || int_rst_r) begin
      wake_cfg_r <= WAKE_CFG_RST;
    end else if (wake_wr) begin
      wake_cfg_r <= PWDATA_I[7:0];
    end
  end

  // Power monitor
  always_comb begin
    pm_state_nxt = pm_state_r;
    if (!SUPPLY_OK_I) begin
      // drop goes straight back to reset
      pm_state_nxt = PM_OFF;
    end else begin
      unique case (pm_state_r)
        PM_OFF: pm_state_nxt = PM_WAIT_XTAL;
        PM_WAIT_XTAL: if (CRYSTAL_OK_I) pm_state_nxt = PM_COUNT;
        PM_COUNT: if (por_done) pm_state_nxt = PM_RUN;
        PM_RUN: pm_state_nxt = PM_RUN;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pm_state_r <= PM_OFF;
    end else begin
      pm_state_r <= pm_state_nxt;
    end
  end

  rpmc_delay #(.COUNT(POR_CYCLES)) u_por_delay (
    .clock_i(CLOCK_I),
    .clear_i(RST_I || pm_state_r != PM_COUNT),
    .run_i(pm_state_r == PM_COUNT),
    .done_o(por_done)
  );

  // Reset-pin filter; the same pin carries our own watchdog pulse back in
  rpmc_delay #(.COUNT(EXT_RST_MIN)) u_ext_rst (
    .clock_i(CLOCK_I),
    .clear_i(RST_I || RST_PIN_N_I),
    .run_i(!RST_PIN_N_I),
    .done_o(ext_rst_done)
  );

  always_ff @(posedge CLOCK_I) begin
    // filtered pin reset also ends idle
    int_rst_r <= RST_I || !SUPPLY_OK_I || pm_state_r != PM_RUN || pin_oe_r ||
                 PCA_WATCHDOG_RST_I || ext_rst_done;
  end

  // Watchdog reset pulse on the open-drain pin
  rpmc_delay #(.COUNT(RST_PULSE)) u_pulse (
    .clock_i(CLOCK_I),
    .clear_i(RST_I || !pin_oe_r),
    .run_i(pin_oe_r),
    .done_o(pulse_done)
  );

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pin_oe_r <= 1'b0;
      pin_val_r <= 1'b1;
    end else if (!pin_oe_r && WATCHDOG_OVF_I) begin
      pin_oe_r <= 1'b1;
      pin_val_r <= 1'b0;
    end else if (pulse_done) begin
      pin_oe_r <= 1'b0;
      pin_val_r <= 1'b1;
    end
  end

  // Wake sources
  assign irq_low = {!EXT_IRQ1_N_I, !EXT_IRQ0_N_I};
  assign irq_fall = irq_prev_r & irq_low;
  assign in_down = (mode_r == MD_DOWN_SLEEP || mode_r == MD_DOWN_OSC ||
                    mode_r == MD_DOWN_KBD);
  assign low_pw = (mode_r != MD_RUN);

  // only enabled sources, level or edge
  assign irq_req[0] = wake_cfg_r[WK_EN_IRQ0_BIT] && (wake_cfg_r[WK_EDGE_IRQ0_BIT] ?
                      (edge_seen_r[0] || irq_fall[0]) : irq_low[0]);
  assign irq_req[1] = wake_cfg_r[WK_EN_IRQ1_BIT] && (wake_cfg_r[WK_EDGE_IRQ1_BIT] ?
                      (edge_seen_r[1] || irq_fall[1]) : irq_low[1]);
  assign kbd_req = wake_cfg_r[WK_EN_KBD_BIT] && KBD_IRQ_I;
  assign usb_req = wake_cfg_r[WK_EN_USB_BIT] && USB_IRQ_I;
  // first held pin to go high ends the exit
  assign release_any = |(held_r & ~irq_low);

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      irq_prev_r <= 2'h0;
      edge_seen_r <= 2'h0;
      held_r <= 2'h0;
    end else begin
      irq_prev_r <= ~irq_low;
      edge_seen_r <= in_down ? (edge_seen_r | irq_fall) : 2'h0;
      held_r <= in_down ? (held_r | irq_req) : 2'h0;
    end
  end

  rpmc_delay #(.COUNT(KBD_CYCLES)) u_kbd_wait (
    .clock_i(CLOCK_I),
    .clear_i(RST_I || mode_r != MD_DOWN_KBD),
    .run_i(mode_r == MD_DOWN_KBD),
    .done_o(kbd_done)
  );

  // Mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    clr_idle = 1'b0;
    clr_both = 1'b0;
    if (int_rst_r) begin
      mode_nxt = MD_RUN;
    end else begin
      unique case (mode_r)
        MD_RUN: begin
          if (pctl_r[PWRDN_BIT]) begin
            mode_nxt = MD_DOWN_SLEEP;
          end else if (pctl_r[IDLE_BIT]) begin
            mode_nxt = MD_IDLE;
          end
        end
        MD_IDLE: begin
          if (IRQ_PENDING_I) begin
            mode_nxt = MD_RUN;
            clr_idle = 1'b1;
          end
        end
        MD_DOWN_SLEEP: begin
          if (|irq_req) begin
            mode_nxt = MD_DOWN_OSC;
          end else if (kbd_req) begin
            mode_nxt = MD_DOWN_KBD;
          end else if (usb_req) begin
            mode_nxt = MD_RUN;
            clr_both = 1'b1;
          end
        end
        MD_DOWN_OSC: begin
          if (release_any) begin
            mode_nxt = MD_RUN;
            clr_both = 1'b1;
          end
        end
        MD_DOWN_KBD: begin
          if (kbd_done) begin
            mode_nxt = MD_RUN;
            clr_both = 1'b1;
          end
        end
        default: mode_nxt = MD_RUN;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mode_r <= MD_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      cpu_en_r <= 1'b1;
      periph_en_r <= 1'b1;
      osc_en_r <= 1'b1;
    end else begin
      cpu_en_r <= (mode_nxt == MD_RUN);
      periph_en_r <= (mode_nxt == MD_RUN || mode_nxt == MD_IDLE);
      osc_en_r <= (mode_nxt != MD_DOWN_SLEEP);
    end
  end

  // Pins and strobes; in idle and power-down port 0 drives only zeros and port 2 ignores the core address select
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ale_r <= 1'b1;
      pstb_r <= 1'b1;
    end else if (in_down) begin
      ale_r <= 1'b0;
      pstb_r <= 1'b0;
    end else if (mode_r == MD_IDLE) begin
      ale_r <= 1'b1;
      pstb_r <= 1'b1;
    end else begin
      ale_r <= ADDR_LATCH_CORE_I;
      pstb_r <= PROG_STROBE_CORE_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      p0_r <= 8'h00;
      p0_oe_r <= 8'h00;
    end else if (!low_pw) begin
      p0_r <= P0_LATCH_I;
      p0_oe_r <= P0_CORE_OE_I;
    end else if (EXT_PROG_MEM_I) begin
      p0_r <= 8'h00;
      p0_oe_r <= 8'h00;
    end else begin
      p0_r <= 8'h00;
      p0_oe_r <= ~P0_LATCH_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      p2_r <= 8'h00;
    end else if (mode_r == MD_IDLE) begin
      p2_r <= EXT_PROG_MEM_I ? P2_ADDR_I : P2_DATA_I;
    end else if (in_down) begin
      p2_r <= P2_DATA_I;
    end else begin
      p2_r <= P2_ADDR_SEL_I ? P2_ADDR_I : P2_DATA_I;
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign RST_PIN_O = pin_val_r;
  assign RST_PIN_OE_O = pin_oe_r;
  assign INTERNAL_RST_O = int_rst_r;
  assign CPU_CLK_EN_O = cpu_en_r;
  assign PERIPH_CLK_EN_O = periph_en_r;
  assign OSC_EN_O = osc_en_r;
  assign BAUD_DOUBLE_O = pctl_r[BAUD_DBL_BIT];
  assign FRAME_ERR_SEL_O = pctl_r[FRAME_SEL_BIT];
  assign ADDR_LATCH_STROBE_O = ale_r;
  assign PROG_STROBE_O = pstb_r;
  assign P0_O = p0_r;
  assign P0_OE_O = p0_oe_r;
  assign P2_O = p2_r;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I || pm_state_r != PM_COUNT) begin
      por_seen_r <= 16'h0000;
    end else begin
      por_seen_r <= por_seen_r + 16'h0001;
    end
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_down_entry;
    mode_r == MD_RUN && pctl_r[PWRDN_BIT] && !int_rst_r;
  endsequence
  sequence s_idle_stable;
    mode_r == MD_IDLE ##1 mode_r == MD_IDLE;
  endsequence
  sequence s_down_stable;
    in_down ##1 in_down;
  endsequence
  sequence s_down_exit;
    (mode_r == MD_DOWN_OSC || mode_r == MD_DOWN_KBD) ##1 mode_r == MD_RUN;
  endsequence
  sequence s_por_end;
    pm_state_r == PM_COUNT ##1 pm_state_r == PM_RUN;
  endsequence

  a_pulse_len: assert property (
    $rose(RST_PIN_OE_O) |-> (RST_PIN_OE_O && !RST_PIN_O throughout (##95 1)) ##1 !RST_PIN_OE_O)
    else $error("reset pin pulse length wrong");
  a_supply_drop: assert property (
    !SUPPLY_OK_I |=> INTERNAL_RST_O && pm_state_r == PM_OFF)
    else $error("supply drop did not reset at once");
  a_por_delay: assert property (
    s_por_end |-> por_seen_r == 16'(POR_CYCLES) && INTERNAL_RST_O)
    else $error("power-up delay count wrong");
  a_down_priority: assert property (
    s_down_entry |=> mode_r == MD_DOWN_SLEEP && !OSC_EN_O)
    else $error("power-down not entered before idle");
  a_idle_strobes: assert property (
    s_idle_stable |-> ADDR_LATCH_STROBE_O && PROG_STROBE_O && !CPU_CLK_EN_O && PERIPH_CLK_EN_O)
    else $error("idle strobes or clocks wrong");
  a_down_strobes: assert property (
    s_down_stable |-> !ADDR_LATCH_STROBE_O && !PROG_STROBE_O && !PERIPH_CLK_EN_O)
    else $error("power-down strobes or clocks wrong");
  a_down_exit: assert property (
    s_down_exit |-> !pctl_r[PWRDN_BIT] && !pctl_r[IDLE_BIT] && CPU_CLK_EN_O)
    else $error("mode bits not cleared on wake");
  a_reset_clears: assert property (
    int_rst_r |=> !pctl_r[PWRDN_BIT] && !pctl_r[IDLE_BIT] && mode_r == MD_RUN)
    else $error("reset did not clear mode");
  a_pof_set: assert property (
    pof_set |=> pctl_r[PWROFF_BIT])
    else $error("power-off flag not set");
  a_p0_drive: assert property (
    $past(low_pw) && !$past(EXT_PROG_MEM_I) |-> P0_OE_O == ~$past(P0_LATCH_I) && P0_O == 8'h00)
    else $error("port 0 drives a one in low power");
  a_rsvd_zero: assert property (
    PREADY_O && PSEL_I && !PWRITE_I && PADDR_I == PCTL_ADDR |-> !PRDATA_O[RSVD_BIT])
    else $error("reserved bit reads one");
endmodule

// *** testbench/rpmc_pins_model.sv ***
`timescale 1ns/100ps
module rpmc_pins_model (
  input wire logic clock_i,
  input wire logic rst_pin_i,
  input wire logic rst_pin_oe_i,
  input wire logic hold_rst_i,
  input wire logic irq0_low_i,
  input wire logic irq1_low_i,
  output logic rst_pin_n_o,
  output logic ext_irq0_n_o,
  output logic ext_irq1_n_o,
  output logic [7:0] hold_cnt_o
);
  // Pull-up pin, low only while a party drives it
  assign rst_pin_n_o = !(rst_pin_oe_i && !rst_pin_i) && !hold_rst_i;
  // Wake pins pulled up, held low on command
  assign ext_irq0_n_o = !irq0_low_i;
  assign ext_irq1_n_o = !irq1_low_i;
  // Length of the outside reset hold, for the bench to see
  always_ff @(posedge clock_i) begin
    hold_cnt_o <= hold_rst_i ? hold_cnt_o + 8'h01 : 8'h00;
  end
endmodule

// *** testbench/reset_and_power_mode_control_tb_top.sv ***
`timescale 1ns/100ps
module reset_and_power_mode_control_tb_top;
  import rpmc_pkg::*;
  localparam int POR_N = 16;
  localparam int KBD_N = 16;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic sup_ok, xtal_ok, wd_ovf, pca, pin_n, pin, pin_oe, irq_p, irq0_n, irq1_n, kbd, usb;
  logic ext_mem, a_core, p_core, p2_sel, a_stb, p_stb, int_rst, cpu_en, per_en, osc_en;
  logic baud, fsel, hold, irq0_low, irq1_low, seen;
  logic [7:0] p0_latch, p0_coe, p2_d, p2_a, p0, p0_oe, p2, hold_cnt;
  int err_count, samples_checked, n, i;

  rpmc_top #(.POR_CYCLES(POR_N), .KBD_CYCLES(KBD_N)) DUT (
    .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SUPPLY_OK_I(sup_ok), .CRYSTAL_OK_I(xtal_ok),
    .WATCHDOG_OVF_I(wd_ovf), .PCA_WATCHDOG_RST_I(pca), .RST_PIN_N_I(pin_n), .RST_PIN_O(pin),
    .RST_PIN_OE_O(pin_oe), .IRQ_PENDING_I(irq_p), .EXT_IRQ0_N_I(irq0_n),
    .EXT_IRQ1_N_I(irq1_n), .KBD_IRQ_I(kbd), .USB_IRQ_I(usb), .EXT_PROG_MEM_I(ext_mem),
    .ADDR_LATCH_CORE_I(a_core), .PROG_STROBE_CORE_I(p_core), .P0_LATCH_I(p0_latch),
    .P0_CORE_OE_I(p0_coe), .P2_DATA_I(p2_d), .P2_ADDR_I(p2_a), .P2_ADDR_SEL_I(p2_sel),
    .P0_O(p0), .P0_OE_O(p0_oe), .P2_O(p2), .ADDR_LATCH_STROBE_O(a_stb),
    .PROG_STROBE_O(p_stb), .INTERNAL_RST_O(int_rst), .CPU_CLK_EN_O(cpu_en),
    .PERIPH_CLK_EN_O(per_en), .OSC_EN_O(osc_en), .BAUD_DOUBLE_O(baud),
    .FRAME_ERR_SEL_O(fsel));

  rpmc_pins_model pins (.clock_i(clk), .rst_pin_i(pin), .rst_pin_oe_i(pin_oe),
    .hold_rst_i(hold), .irq0_low_i(irq0_low), .irq1_low_i(irq1_low), .rst_pin_n_o(pin_n),
    .ext_irq0_n_o(irq0_n), .ext_irq1_n_o(irq1_n), .hold_cnt_o(hold_cnt));

  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Answer is taken at the edge where pready is seen high, before it updates
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      err_count++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_rel(output int c);
    for (c = 0; c < 4000; c++) begin
      @(posedge clk);
      if (int_rst === 1'b0) break;
    end
    if (c == 4000) begin
      err_count++;
      end_sim();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rst, sup_ok, xtal_ok} = 3'b111;
    {psel, penable, pwrite, wd_ovf, pca, irq_p, kbd, usb, ext_mem, hold} = '0;
    {irq0_low, irq1_low, a_core, p_core} = 4'b0011;
    paddr = '0;
    pwdata = '0;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(95313));
    {p0_latch, p0_coe, p2_d, p2_a} = $urandom;
    p2_sel = $urandom;
    tick(4);
    rst <= 1'b0;
    wait_rel(n);
    cmp(32'(n >= POR_N && n <= POR_N + 6), 32'h1);
    apb(1'b0, PCTL_ADDR, 32'h0);
    cmp(rd, 32'h10);
    for (i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hFC : ($urandom & 32'hFC);
      apb(1'b1, PCTL_ADDR, v);
      apb(1'b0, PCTL_ADDR, 32'h0);
      cmp(rd, v & 32'hDC);
      cmp({30'h0, baud, fsel}, (v >> 6) & 32'h3);
    end
    apb(1'b0, 12'h004, 32'h0);
    cmp({31'h0, er}, 32'h1);
    cmp(rd, 32'h0);
    apb(1'b1, PCTL_ADDR, 32'h01);
    tick(3);
    cmp({29'h0, cpu_en, per_en, osc_en}, 32'h3);
    cmp({30'h0, a_stb, p_stb}, 32'h3);
    cmp({16'h0, p0_oe, p0}, {16'h0, ~p0_latch, 8'h00});
    irq_p <= 1'b1;
    tick(2);
    irq_p <= 1'b0;
    cmp({31'h0, cpu_en}, 32'h1);
    apb(1'b0, PCTL_ADDR, 32'h0);
    cmp(rd & 32'h3, 32'h0);
    apb(1'b1, PCTL_ADDR, 32'h01);
    tick(2);
    hold <= 1'b1;
    seen = 1'b0;
    for (i = 0; i < 28; i++) begin
      @(posedge clk);
      seen = seen | (int_rst === 1'b1);
    end
    cmp(32'(hold_cnt >= EXT_RST_MIN_CYCLES), 32'h1);
    hold <= 1'b0;
    cmp({31'h0, seen}, 32'h1);
    wait_rel(n);
    apb(1'b0, PCTL_ADDR, 32'h0);
    cmp(rd & 32'h3, 32'h0);
    // Pass 0: level wake on pin 0; pass 1: edge wake on pin 1 with external memory
    for (i = 0; i < 2; i++) begin
      ext_mem <= i[0];
      apb(1'b1, WAKE_CFG_ADDR, (i == 0) ? 32'h01 : 32'h22);
      apb(1'b1, PCTL_ADDR, 32'h03);
      tick(3);
      cmp({29'h0, cpu_en, per_en, osc_en}, 32'h0);
      cmp({30'h0, a_stb, p_stb}, 32'h0);
      cmp({16'h0, p0_oe, p2}, {16'h0, (i == 0) ? ~p0_latch : 8'h00, p2_d});
      usb <= 1'b1;
      tick(3);
      usb <= 1'b0;
      cmp({31'h0, osc_en}, 32'h0);
      irq0_low <= !i[0];
      irq1_low <= i[0];
      tick(2);
      cmp({30'h0, osc_en, cpu_en}, 32'h2);
      irq0_low <= 1'b0;
      irq1_low <= 1'b0;
      tick(3);
      cmp({29'h0, cpu_en, per_en, osc_en}, 32'h7);
      apb(1'b0, PCTL_ADDR, 32'h0);
      cmp(rd & 32'h3, 32'h0);
      apb(1'b0, WAKE_CFG_ADDR, 32'h0);
      cmp(rd, (i == 0) ? 32'h01 : 32'h22);
    end
    ext_mem <= 1'b0;
    apb(1'b1, WAKE_CFG_ADDR, 32'h04);
    apb(1'b1, PCTL_ADDR, 32'h02);
    tick(3);
    kbd <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (cpu_en === 1'b1) break;
    end
    kbd <= 1'b0;
    cmp(32'(n >= KBD_N && n <= KBD_N + 4), 32'h1);
    wd_ovf <= 1'b1;
    tick(1);
    wd_ovf <= 1'b0;
    n = 0;
    seen = 1'b0;
    for (i = 0; i < 130; i++) begin
      @(posedge clk);
      n += int'(pin_oe === 1'b1 && pin === 1'b0);
      seen = seen | (int_rst === 1'b1);
    end
    cmp(32'(n), 32'd96);
    cmp({31'h0, seen}, 32'h1);
    wait_rel(n);
    sup_ok <= 1'b0;
    tick(2);
    cmp({31'h0, int_rst}, 32'h1);
    tick(20);
    cmp({31'h0, int_rst}, 32'h1);
    sup_ok <= 1'b1;
    wait_rel(n);
    cmp(32'(n >= POR_N), 32'h1);
    pca <= 1'b1;
    tick(3);
    cmp({31'h0, int_rst}, 32'h1);
    pca <= 1'b0;
    wait_rel(n);
    end_sim();
  end
endmodule
